// File: include/tsil_regs.svh
// Constants for the target sequence and interrupt status logic
//
// How it works
// [RQ1] Conclude: status, command-complete message, then release busy
// [RQ2] Disconnect reported only when function-done enable set
// [RQ3] Report command state code of last good phase
// [RQ4] Conclude: attention after status/message stops, flags attention
// [RQ5] Bus reset interrupt possible in any phase
// [RQ6] Chip reset command or master reset aborts command
// [RQ7] Host preloads status then linked message into transmit FIFO
// [RQ8] Link: status-in, message-in, command-out from transmit FIFO
// [RQ9] Command bytes of link go into receive FIFO
// [RQ10] Link: attention after status/message terminates, flags attention
// [RQ11] Parity: first byte sets parity and halt, later parity only
// [RQ12] Full command descriptor received sets function-done; code sets it only if the last byte had no parity error
// [RQ13] Pending interrupts shown as poll bit and request line
// [RQ14] Request line driven only while master enable set
// [RQ15] Any error flag also sets error summary flag
// [RQ16] Any status flag may raise interrupt, subject to enables
// [RQ17] Both status registers captured at start of read
// [RQ18] Read clears flags active at its start, except summary
// [RQ19] Error summary cleared only by error register read
// [RQ20] Interrupts during a read are loaded after it ends
// [RQ21] Request line receiver must be level sensitive
// [RQ22] Function-done and attention gated by own enables
// [RQ23] Poll bit ignores master enable
`ifndef TSIL_REGS_SVH
`define TSIL_REGS_SVH

// ----------------------------------------------------------------
// Command state codes
// ----------------------------------------------------------------
`define TSIL_CSC_NONE      4'h0
`define TSIL_CSC_CDB_START 4'h3
`define TSIL_CSC_CDB_DONE  4'h4
`define TSIL_CSC_STAT_SENT 4'hC
`define TSIL_CSC_MSG_SENT  4'hD
`define TSIL_CSC_DISC      4'hE

// ----------------------------------------------------------------
// Functional and error status bit positions
// ----------------------------------------------------------------
`define TSIL_FW        4
`define TSIL_EW        2
`define TSIL_F_FDONE   0
`define TSIL_F_ATTN    1
`define TSIL_F_BUSRST  2
`define TSIL_F_ESUM    3
`define TSIL_E_PARITY  0
`define TSIL_E_HALT    1

// ----------------------------------------------------------------
// Bytes and descriptor lengths
// ----------------------------------------------------------------
`define TSIL_MSG_CMD_COMPLETE 8'h00
`define TSIL_CDB_LEN_G0       4'h6
`define TSIL_CDB_LEN_G12      4'hA
`define TSIL_CDB_LEN_G5       4'hC
`define TSIL_CDB_GRP_LSB      5

`endif

// File: include/tsil_pkg.sv
// Types shared by the target sequence and interrupt status logic
package tsil_pkg;

	// Commands accepted on the command port
	typedef enum logic [1:0] {
		TSIL_CMD_CONCLUDE   = 2'h0,
		TSIL_CMD_LINK       = 2'h1,
		TSIL_CMD_CHIP_RESET = 2'h2,
		TSIL_CMD_NOP        = 2'h3
	} tsil_cmd_t;

	// Byte engine states
	typedef enum logic [2:0] {
		TSIL_S_IDLE  = 3'h0,
		TSIL_S_LOAD  = 3'h1,
		TSIL_S_REQ   = 3'h2,
		TSIL_S_REL   = 3'h3,
		TSIL_S_CHECK = 3'h4,
		TSIL_S_DISC  = 3'h5
	} tsil_state_t;

	// Bus information phase being driven
	typedef enum logic [1:0] {
		TSIL_PH_STATUS = 2'h0,
		TSIL_PH_MSGIN  = 2'h1,
		TSIL_PH_CMDOUT = 2'h2
	} tsil_phase_t;

endpackage

// File: hw/tsil_buf2.sv
// Two-entry buffer between command-out capture and receive FIFO port
`timescale 1ns/1ps
module tsil_buf2 #(
	parameter int W = 8
) (
	input  wire logic         mclk,
	input  wire logic         rst,
	input  wire logic [W-1:0] in_data,
	input  wire logic         in_valid,
	output logic              in_ready,
	output logic [W-1:0]      out_data,
	output logic              out_valid,
	input  wire logic         out_ready
);
	generate
		if (W < 1) begin : g_chk
			$error("tsil_buf2: width must be positive");
		end
	endgenerate

	logic [W-1:0] mem_ff [2];
	logic         wp_ff;
	logic         rp_ff;
	logic [1:0]   cnt_ff;
	logic         push;
	logic         pop;

	// Honest full and empty from the fill count
	assign in_ready  = (cnt_ff != 2'h2);
	assign out_valid = (cnt_ff != 2'h0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// Storage write side
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			mem_ff[0] <= '0;
			mem_ff[1] <= '0;
			wp_ff     <= 1'b0;
		end else if (push) begin
			mem_ff[wp_ff] <= in_data;
			wp_ff         <= ~wp_ff;
		end
	end

	// Read pointer and count
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rp_ff  <= 1'b0;
			cnt_ff <= 2'h0;
		end else begin
			if (pop)
				rp_ff <= ~rp_ff;
			if (push && !pop)
				cnt_ff <= cnt_ff + 2'h1;
			else if (pop && !push)
				cnt_ff <= cnt_ff - 2'h1;
		end
	end

	assign out_data = mem_ff[rp_ff];
endmodule

// File: hw/tsil_irq_status.sv
// Functional and error interrupt status registers with read capture
`timescale 1ns/1ps
`include "tsil_regs.svh"
module tsil_irq_status
	import tsil_pkg::*;
(
	input  wire logic                mclk,
	input  wire logic                rst,
	input  wire logic [`TSIL_FW-1:0] f_set,
	input  wire logic [`TSIL_EW-1:0] e_set,
	input  wire logic                rd_active,
	input  wire logic                rd_sel_error,
	input  wire logic                master_irq_enable,
	input  wire logic                function_done_irq_enable,
	input  wire logic                attention_irq_enable,
	output logic [7:0]               rd_data,
	output logic                     int_pending,
	output logic                     irq_request_line
);
	logic [`TSIL_FW-1:0] functional_irq_status_ff, nxt_functional_irq_status, snap_f_ff, pend_f_ff;
	logic [`TSIL_EW-1:0] error_irq_status_ff, nxt_error_irq_status, snap_e_ff, pend_e_ff;
	logic                rd_q_ff;
	logic                rd_start;
	logic                rd_end;
	logic [`TSIL_FW-1:0] f_in, f_mask, clr_f;

	// Error events also raise the summary flag
	always_comb begin
		f_in = f_set;
		f_in[`TSIL_F_ESUM] = f_set[`TSIL_F_ESUM] | (|e_set); // see [RQ15]
	end

	assign rd_start = rd_active && !rd_q_ff;
	assign rd_end   = !rd_active && rd_q_ff;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			rd_q_ff <= 1'b0;
		else
			rd_q_ff <= rd_active;
	end

	// Snapshot of both registers and the stable read data
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			snap_f_ff <= '0;
			snap_e_ff <= '0;
			rd_data   <= 8'h00;
		end else if (rd_start) begin
			snap_f_ff <= functional_irq_status_ff; // see [RQ17]
			snap_e_ff <= error_irq_status_ff;
			rd_data   <= rd_sel_error ? {{(8-`TSIL_EW){1'b0}}, error_irq_status_ff} : {{(8-`TSIL_FW){1'b0}}, functional_irq_status_ff};
		end
	end

	// Events during a read wait here until it ends
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pend_f_ff <= '0;
			pend_e_ff <= '0;
		end else if (rd_active) begin
			pend_f_ff <= pend_f_ff | f_in; // see [RQ20]
			pend_e_ff <= pend_e_ff | e_set;
		end else begin
			pend_f_ff <= '0;
			pend_e_ff <= '0;
		end
	end

	// Clear set at read end; summary only on an error read
	always_comb begin
		clr_f = rd_sel_error ? '0 : snap_f_ff; // see [RQ18]
		clr_f[`TSIL_F_ESUM] = rd_sel_error; // see [RQ19]
		nxt_functional_irq_status = functional_irq_status_ff;
		nxt_error_irq_status = error_irq_status_ff;
		if (rd_end) begin
			// Held and current events win over the clear
			nxt_functional_irq_status = (functional_irq_status_ff & ~clr_f) | pend_f_ff | f_in; // see [RQ20]
			nxt_error_irq_status = (error_irq_status_ff & ~(rd_sel_error ? snap_e_ff : '0)) | pend_e_ff | e_set;
		end else if (!rd_active) begin
			nxt_functional_irq_status = functional_irq_status_ff | f_in;
			nxt_error_irq_status = error_irq_status_ff | e_set;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			functional_irq_status_ff <= '0;
			error_irq_status_ff <= '0;
		end else begin
			functional_irq_status_ff <= nxt_functional_irq_status;
			error_irq_status_ff <= nxt_error_irq_status;
		end
	end

	// Enable gating; the poll bit ignores the master enable
	always_comb begin
		f_mask = '1;
		f_mask[`TSIL_F_FDONE] = function_done_irq_enable; // see [RQ22], [RQ2]
		f_mask[`TSIL_F_ATTN]  = attention_irq_enable;
	end

	assign int_pending      = (|(functional_irq_status_ff & f_mask)) | (|error_irq_status_ff); // see [RQ16], [RQ23], [RQ13]
	assign irq_request_line = int_pending && master_irq_enable; // see [RQ14]
endmodule

// File: hw/tsil_core.sv
// Target conclude and link sequences with interrupt reporting
`timescale 1ns/1ps
`include "tsil_regs.svh"
module tsil_core
	import tsil_pkg::*;
#(
	parameter int DW = 8
) (
	input  wire logic          mclk,
	input  wire logic          rst,
	input  wire logic          cmd_valid,
	input  wire tsil_cmd_t     cmd_code,
	output logic               cmd_busy,
	output logic [3:0]         cmd_state_code,
	input  wire logic [DW-1:0] tx_data,
	input  wire logic          tx_valid,
	output logic               tx_ready,
	output logic [DW-1:0]      rx_data,
	output logic               rx_valid,
	input  wire logic          rx_ready,
	output logic [DW-1:0]      bus_data_out,
	output logic               bus_data_oe,
	input  wire logic [DW-1:0] bus_data_in,
	input  wire logic          bus_parity_err,
	output logic               bus_req,
	input  wire logic          bus_ack,
	input  wire logic          bus_atn,
	input  wire logic          bus_rst_in,
	output logic               bus_bsy,
	output logic               bus_io,
	output logic               bus_cd,
	output logic               bus_msg,
	input  wire logic          stat_rd_active,
	input  wire logic          stat_rd_sel_error,
	output logic [7:0]         stat_rd_data,
	input  wire logic          master_irq_enable,
	input  wire logic          function_done_irq_enable,
	input  wire logic          attention_irq_enable,
	output logic               int_pending,
	output logic               irq_request_line
);
	generate
		if (DW != 8) begin : g_chk
			$error("tsil_core: bus data width must be 8");
		end
	endgenerate

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	tsil_state_t         state_ff, nxt_state;
	tsil_phase_t         phase_ff, nxt_phase;
	logic                link_ff, nxt_link;
	logic                bsy_ff, nxt_bsy;
	logic [3:0]          csc_ff, nxt_csc;
	logic [DW-1:0]       dout_ff, nxt_dout;
	logic [3:0]          cnt_ff, nxt_cnt;
	logic [3:0]          len_ff, nxt_len;
	logic                perr_ff, nxt_perr;
	logic [`TSIL_FW-1:0] f_set_ff, nxt_f_set;
	logic [`TSIL_EW-1:0] e_set_ff, nxt_e_set;
	logic                buf_in_ready;
	logic                buf_push;
	logic                abort;

	// Length of a command descriptor from its group code
	function automatic logic [3:0] cdb_len(input logic [DW-1:0] opc);
		case (opc[DW-1:`TSIL_CDB_GRP_LSB])
			3'h1, 3'h2: cdb_len = `TSIL_CDB_LEN_G12;
			3'h5:       cdb_len = `TSIL_CDB_LEN_G5;
			default:    cdb_len = `TSIL_CDB_LEN_G0;
		endcase
	endfunction

	// Phase line decode, used by the engine outputs
	function automatic logic [2:0] phase_lines(input tsil_phase_t ph);
		case (ph)
			TSIL_PH_STATUS: phase_lines = 3'h6; // io, cd, msg
			TSIL_PH_MSGIN:  phase_lines = 3'h7;
			TSIL_PH_CMDOUT: phase_lines = 3'h2;
			default:        phase_lines = 3'h0;
		endcase
	endfunction

	// Bus reset or chip reset command kills any sequence
	assign abort = bus_rst_in || (cmd_valid && cmd_code == TSIL_CMD_CHIP_RESET); // see [RQ6], [RQ5]

	// ----------------------------------------------------------------
	// Sequence engine
	// ----------------------------------------------------------------
	always_comb begin
		nxt_state = state_ff;
		nxt_phase = phase_ff;
		nxt_link  = link_ff;
		nxt_bsy   = bsy_ff;
		nxt_csc   = csc_ff;
		nxt_dout  = dout_ff;
		nxt_cnt   = cnt_ff;
		nxt_len   = len_ff;
		nxt_perr  = perr_ff;
		nxt_f_set = '0;
		nxt_e_set = '0;
		tx_ready  = 1'b0;
		buf_push  = 1'b0;
		if (abort) begin
			nxt_state = TSIL_S_IDLE;
			nxt_bsy   = 1'b0;
			nxt_f_set[`TSIL_F_BUSRST] = bus_rst_in; // see [RQ5]
		end else begin
			case (state_ff)
				TSIL_S_IDLE: begin
					if (cmd_valid && (cmd_code == TSIL_CMD_CONCLUDE || cmd_code == TSIL_CMD_LINK)) begin
						nxt_link  = (cmd_code == TSIL_CMD_LINK);
						nxt_phase = TSIL_PH_STATUS;
						nxt_bsy   = 1'b1;
						nxt_csc   = `TSIL_CSC_NONE;
						nxt_state = TSIL_S_LOAD;
					end
				end
				TSIL_S_LOAD: begin
					if (phase_ff == TSIL_PH_CMDOUT) begin
						// Hold off the next byte while the buffer is full
						if (buf_in_ready)
							nxt_state = TSIL_S_REQ;
					end else if (phase_ff == TSIL_PH_MSGIN && !link_ff) begin
						nxt_dout  = `TSIL_MSG_CMD_COMPLETE; // see [RQ1]
						nxt_state = TSIL_S_REQ;
					end else if (tx_valid) begin
						tx_ready  = 1'b1; // see [RQ8], [RQ7]
						nxt_dout  = tx_data;
						nxt_state = TSIL_S_REQ;
					end
				end
				TSIL_S_REQ: begin
					if (bus_ack) begin
						if (phase_ff == TSIL_PH_CMDOUT) begin
							buf_push = 1'b1; // see [RQ9]
							nxt_perr = bus_parity_err;
							if (cnt_ff == 4'h0)
								nxt_len = cdb_len(bus_data_in);
						end
						nxt_state = TSIL_S_REL;
					end
				end
				TSIL_S_REL: begin
					if (!bus_ack)
						nxt_state = TSIL_S_CHECK;
				end
				TSIL_S_CHECK: begin
					case (phase_ff)
						TSIL_PH_STATUS: begin
							nxt_csc = `TSIL_CSC_STAT_SENT; // see [RQ3]
							if (bus_atn) begin
								nxt_f_set[`TSIL_F_ATTN] = 1'b1; // see [RQ4], [RQ10]
								nxt_state = TSIL_S_IDLE;
							end else begin
								nxt_phase = TSIL_PH_MSGIN; // see [RQ1], [RQ8]
								nxt_state = TSIL_S_LOAD;
							end
						end
						TSIL_PH_MSGIN: begin
							nxt_csc = `TSIL_CSC_MSG_SENT; // see [RQ3]
							if (bus_atn) begin
								nxt_f_set[`TSIL_F_ATTN] = 1'b1; // see [RQ4], [RQ10]
								nxt_state = TSIL_S_IDLE;
							end else if (link_ff) begin
								nxt_phase = TSIL_PH_CMDOUT; // see [RQ8]
								nxt_cnt   = 4'h0;
								nxt_state = TSIL_S_LOAD;
							end else begin
								nxt_state = TSIL_S_DISC;
							end
						end
						default: begin
							nxt_csc = `TSIL_CSC_CDB_START;
							nxt_cnt = cnt_ff + 4'h1;
							if (perr_ff) begin
								nxt_e_set[`TSIL_E_PARITY] = 1'b1; // see [RQ11]
								nxt_e_set[`TSIL_E_HALT]   = (cnt_ff == 4'h0);
							end
							if (perr_ff && cnt_ff == 4'h0) begin
								nxt_state = TSIL_S_IDLE;
							end else if (cnt_ff + 4'h1 == len_ff) begin
								nxt_csc = `TSIL_CSC_CDB_DONE; // see [RQ12]
								nxt_f_set[`TSIL_F_FDONE] = !perr_ff;
								nxt_state = TSIL_S_IDLE;
							end else begin
								nxt_state = TSIL_S_LOAD;
							end
						end
					endcase
				end
				TSIL_S_DISC: begin
					// Busy released, then completion flagged
					nxt_bsy   = 1'b0; // see [RQ1]
					nxt_csc   = `TSIL_CSC_DISC;
					nxt_f_set[`TSIL_F_FDONE] = 1'b1; // see [RQ4], [RQ2]
					nxt_state = TSIL_S_IDLE;
				end
				default: nxt_state = TSIL_S_IDLE;
			endcase
		end
	end

	// Engine state and phase
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_ff <= TSIL_S_IDLE; // see [RQ6]
			phase_ff <= TSIL_PH_STATUS;
			link_ff  <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			phase_ff <= nxt_phase;
			link_ff  <= nxt_link;
		end
	end

	// Bus drive registers
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			bsy_ff  <= 1'b0;
			dout_ff <= '0;
		end else begin
			bsy_ff  <= nxt_bsy;
			dout_ff <= nxt_dout;
		end
	end

	// Descriptor counting and state code
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cnt_ff  <= 4'h0;
			len_ff  <= `TSIL_CDB_LEN_G0;
			perr_ff <= 1'b0;
			csc_ff  <= `TSIL_CSC_NONE;
		end else begin
			cnt_ff  <= nxt_cnt;
			len_ff  <= nxt_len;
			perr_ff <= nxt_perr;
			csc_ff  <= nxt_csc;
		end
	end

	// Event pulses toward the status registers
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			f_set_ff <= '0;
			e_set_ff <= '0;
		end else begin
			f_set_ff <= nxt_f_set;
			e_set_ff <= nxt_e_set;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Phase lines stay valid only while connected
	assign {bus_io, bus_cd, bus_msg} = bsy_ff ? phase_lines(phase_ff) : 3'h0;
	assign bus_bsy        = bsy_ff;
	assign bus_req        = (state_ff == TSIL_S_REQ);
	assign bus_data_out   = dout_ff;
	assign bus_data_oe    = bsy_ff && (phase_ff != TSIL_PH_CMDOUT);
	assign cmd_busy       = (state_ff != TSIL_S_IDLE);
	assign cmd_state_code = csc_ff; // see [RQ3]

	// ----------------------------------------------------------------
	// Receive path and status registers
	// ----------------------------------------------------------------
	tsil_buf2 #(
		.W (DW)
	) u_rx_buf (
		.mclk      (mclk),
		.rst       (rst),
		.in_data   (bus_data_in),
		.in_valid  (buf_push),
		.in_ready  (buf_in_ready),
		.out_data  (rx_data),
		.out_valid (rx_valid),
		.out_ready (rx_ready)
	);

	tsil_irq_status u_irq (
		.mclk                     (mclk),
		.rst                      (rst),
		.f_set                    (f_set_ff),
		.e_set                    (e_set_ff),
		.rd_active                (stat_rd_active),
		.rd_sel_error             (stat_rd_sel_error),
		.master_irq_enable        (master_irq_enable),
		.function_done_irq_enable (function_done_irq_enable),
		.attention_irq_enable     (attention_irq_enable),
		.rd_data                  (stat_rd_data),
		.int_pending              (int_pending),
		.irq_request_line         (irq_request_line)
	);
endmodule

// File: dv/tsil_sva.sv
// Port-level checks on the target sequence core
`timescale 1ns/1ps
module tsil_sva
	import tsil_pkg::*;
(
	input wire logic       mclk,
	input wire logic       rst,
	input wire logic       cmd_valid,
	input wire tsil_cmd_t  cmd_code,
	input wire logic       cmd_busy,
	input wire logic [3:0] cmd_state_code,
	input wire logic [7:0] bus_data_out,
	input wire logic       bus_data_oe,
	input wire logic       bus_req,
	input wire logic       bus_ack,
	input wire logic       bus_rst_in,
	input wire logic       bus_bsy,
	input wire logic       bus_io,
	input wire logic       bus_cd,
	input wire logic       bus_msg,
	input wire logic       stat_rd_active,
	input wire logic [7:0] stat_rd_data,
	input wire logic       master_irq_enable,
	input wire logic       int_pending,
	input wire logic       irq_request_line
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	// ----------------------------------------------------------------
	// Sequences of the command and byte handshake
	// ----------------------------------------------------------------
	sequence start_s;
		cmd_valid && !cmd_busy && cmd_code inside {TSIL_CMD_CONCLUDE, TSIL_CMD_LINK};
	endsequence
	sequence hs_s;
		bus_req && bus_ack;
	endsequence
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	cmd_start_a: assert property (start_s |=> cmd_busy && cmd_state_code == 4'h0)
		else $error("command start not taken");
	req_drop_a: assert property (hs_s |=> !bus_req)
		else $error("request held after acknowledge");
	data_hold_a: assert property (bus_req && $past(bus_req) |-> $stable(bus_data_out))
		else $error("bus data moved during request");
	req_conn_a: assert property (bus_req |-> bus_bsy && cmd_busy)
		else $error("request while not connected");
	phase_idle_a: assert property (!bus_bsy |-> !(bus_io || bus_cd || bus_msg))
		else $error("phase lines set while idle");
	cmd_dir_a: assert property (bus_cd && !bus_io |-> !bus_data_oe)
		else $error("data driven in command-out");
	rst_abort_a: assert property ($rose(bus_rst_in) && !stat_rd_active |-> ##[1:3] !cmd_busy ##[1:4] int_pending)
		else $error("bus reset not aborting or flagged");
	irq_gate_a: assert property (irq_request_line == (int_pending && master_irq_enable))
		else $error("request line gating wrong");
	rd_hold_a: assert property (stat_rd_active && $past(stat_rd_active) |=> $stable(stat_rd_data))
		else $error("status read data changed");
endmodule

bind tsil_core tsil_sva i_tsil_sva (.mclk, .rst, .cmd_valid, .cmd_code, .cmd_busy, .cmd_state_code,
	.bus_data_out, .bus_data_oe, .bus_req, .bus_ack, .bus_rst_in, .bus_bsy, .bus_io, .bus_cd, .bus_msg,
	.stat_rd_active, .stat_rd_data, .master_irq_enable, .int_pending, .irq_request_line);

// File: dv/tsil_init_model.sv
// Behavioural initiator on the far side of the target bus
`timescale 1ns/1ps
module tsil_init_model (
	input  wire logic       mclk,
	input  wire logic       bus_req,
	input  wire logic       bus_io,
	input  wire logic [7:0] bus_data_out,
	input  wire integer     lag,
	input  wire integer     perr_idx,
	output logic            bus_ack,
	output logic [7:0]      bus_data_in,
	output logic            bus_parity_err
);
	logic [7:0] got[$];
	int         n;
	// Handshake: acknowledge after lag cycles, release once request drops
	initial begin
		bus_ack = 1'b0;
		bus_data_in = 8'h5A;
		bus_parity_err = 1'b0;
		n = 0;
		forever begin
			@(posedge mclk);
			#1;
			if (bus_req) begin
				repeat (lag) @(posedge mclk);
				#1;
				if (bus_io) begin
					got.push_back(bus_data_out);
				end else begin
					// Group zero descriptor: bytes count up from zero
					bus_data_in = n[7:0];
					bus_parity_err = (n == perr_idx);
					n++;
				end
				bus_ack = 1'b1;
				while (bus_req) begin
					@(posedge mclk);
					#1;
				end
				bus_ack = 1'b0;
				// Released lines must not keep the last value
				bus_data_in = ~bus_data_in;
				bus_parity_err = 1'b0;
			end
		end
	end
endmodule

// File: dv/tb.sv
// Self-checking bench for the target sequence core
`timescale 1ns/1ps
module tb
	import tsil_pkg::*;
;
	logic       mclk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, tx_valid = 1'b0, rx_ready = 1'b1, bus_atn = 1'b0;
	logic       bus_rst_in = 1'b0, stat_rd_active = 1'b0, stat_rd_sel_error = 1'b0, take = 1'b0;
	logic       master_irq_enable = 1'b1, function_done_irq_enable = 1'b1, attention_irq_enable = 1'b1;
	tsil_cmd_t  cmd_code = TSIL_CMD_NOP;
	logic [7:0] tx_data = 8'h00, bus_data_in, stat_rd_data, bus_data_out, rx_data, rd_val;
	logic [3:0] cmd_state_code;
	logic       cmd_busy, tx_ready, rx_valid, bus_data_oe, bus_parity_err, bus_req, bus_ack;
	logic       bus_bsy, bus_io, bus_cd, bus_msg, int_pending, irq_request_line;
	logic [7:0] txq[$], rxq[$];
	int         num_errors = 0, tests_run = 0, lag = 0, perr_idx = -1;

	tsil_core i_tsil_core (.mclk, .rst, .cmd_valid, .cmd_code, .cmd_busy, .cmd_state_code, .tx_data,
		.tx_valid, .tx_ready, .rx_data, .rx_valid, .rx_ready, .bus_data_out, .bus_data_oe, .bus_data_in,
		.bus_parity_err, .bus_req, .bus_ack, .bus_atn, .bus_rst_in, .bus_bsy, .bus_io, .bus_cd, .bus_msg,
		.stat_rd_active, .stat_rd_sel_error, .stat_rd_data, .master_irq_enable, .function_done_irq_enable,
		.attention_irq_enable, .int_pending, .irq_request_line);
	tsil_init_model i_init (.mclk, .bus_req, .bus_io, .bus_data_out, .lag, .perr_idx, .bus_ack,
		.bus_data_in, .bus_parity_err);

	// Clock, transmit source and receive sink
	always #12.5 mclk = ~mclk;
	always @(negedge mclk) take = tx_ready && tx_valid;
	always @(negedge mclk) if (rx_valid && rx_ready) rxq.push_back(rx_data);
	always @(posedge mclk) begin
		if (take) void'(txq.pop_front());
		tx_valid <= txq.size() != 0;
		tx_data <= (txq.size() != 0) ? txq[0] : 8'hFF;
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic conclude();
		if (num_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic cycles(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic issue(input tsil_cmd_t c);
		i_init.got.delete();
		i_init.n = 0;
		rxq.delete();
		@(posedge mclk);
		cmd_valid <= 1'b1;
		cmd_code <= c;
		@(posedge mclk);
		cmd_valid <= 1'b0;
	endtask
	// Attention rises once atn_at bytes reached the initiator
	task automatic wait_idle(input int atn_at);
		repeat (4000) begin
			@(posedge mclk);
			if (i_init.got.size() == atn_at) bus_atn <= 1'b1;
			@(negedge mclk);
			if (cmd_busy === 1'b0) break;
		end
		@(posedge mclk);
		bus_atn <= 1'b0;
		cycles(4);
		@(negedge mclk);
		check("busy", {7'h0, cmd_busy}, 8'h00);
	endtask
	task automatic cmd(input tsil_cmd_t c, input int atn_at);
		issue(c);
		wait_idle(atn_at);
	endtask
	task automatic rd_begin(input logic sel);
		@(posedge mclk);
		stat_rd_sel_error <= sel;
		stat_rd_active <= 1'b1;
		cycles(2);
		@(negedge mclk);
		rd_val = stat_rd_data;
	endtask
	task automatic rd_end();
		@(posedge mclk);
		stat_rd_active <= 1'b0;
		cycles(4);
		@(negedge mclk);
	endtask
	task automatic rd(input logic sel, input logic [7:0] exp);
		rd_begin(sel);
		check("status read", rd_val, exp);
		rd_end();
	endtask
	task automatic load_link();
		txq.push_back(8'h02);
		txq.push_back(8'h0A);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		cycles(20);
		rst <= 1'b0;
		cycles(2);
		// Conclude with completion reported
		txq.push_back(8'h02);
		cmd(TSIL_CMD_CONCLUDE, -1);
		check("status byte", i_init.got[0], 8'h02);
		check("message byte", i_init.got[1], 8'h00);
		check("state code", {4'h0, cmd_state_code}, 8'h0E);
		check("request line", {7'h0, irq_request_line}, 8'h01);
		rd(1'b0, 8'h01);
		check("poll bit", {7'h0, int_pending}, 8'h00);
		// Completion not reported when its enable is off
		@(posedge mclk) function_done_irq_enable <= 1'b0;
		txq.push_back(8'h02);
		cmd(TSIL_CMD_CONCLUDE, -1);
		check("poll bit", {7'h0, int_pending}, 8'h00);
		rd_begin(1'b0);
		rd_end();
		// Attention after message, master enable off
		function_done_irq_enable <= 1'b1;
		master_irq_enable <= 1'b0;
		txq.push_back(8'h02);
		cmd(TSIL_CMD_CONCLUDE, 2);
		check("state code", {4'h0, cmd_state_code}, 8'h0D);
		check("poll bit", {7'h0, int_pending}, 8'h01);
		check("request line", {7'h0, irq_request_line}, 8'h00);
		rd(1'b0, 8'h02);
		// Link with attention after status
		master_irq_enable <= 1'b1;
		attention_irq_enable <= 1'b0;
		load_link();
		cmd(TSIL_CMD_LINK, 0);
		check("state code", {4'h0, cmd_state_code}, 8'h0C);
		check("poll bit", {7'h0, int_pending}, 8'h00);
		rd(1'b0, 8'h02);
		attention_irq_enable <= 1'b1;
		txq.delete();
		// Full link, receiver stalls until the buffer refuses
		load_link();
		rx_ready <= 1'b0;
		issue(TSIL_CMD_LINK);
		cycles(80);
		@(negedge mclk);
		check("bytes while stalled", i_init.n[7:0], 8'h02);
		@(posedge mclk) rx_ready <= 1'b1;
		wait_idle(-1);
		check("message byte", i_init.got[1], 8'h0A);
		check("state code", {4'h0, cmd_state_code}, 8'h04);
		check("received count", rxq.size(), 8'h06);
		foreach (rxq[i]) check("received byte", rxq[i], i);
		rd(1'b0, 8'h01);
		// Parity error on first and on a later command byte, slow initiator
		lag = 2;
		for (int k = 0; k < 2; k++) begin
			perr_idx = k * 2;
			load_link();
			cmd(TSIL_CMD_LINK, -1);
			check("state code", {4'h0, cmd_state_code}, k ? 8'h04 : 8'h03);
			rd(1'b0, k ? 8'h09 : 8'h08);
			rd(1'b0, 8'h08);
			rd(1'b1, k ? 8'h01 : 8'h03);
			rd(1'b0, 8'h00);
			txq.delete();
		end
		perr_idx = -1;
		lag = 0;
		// Bus reset during a stalled link
		load_link();
		rx_ready <= 1'b0;
		issue(TSIL_CMD_LINK);
		cycles(60);
		bus_rst_in <= 1'b1;
		cycles(2);
		bus_rst_in <= 1'b0;
		rx_ready <= 1'b1;
		wait_idle(-1);
		check("busy line", {7'h0, bus_bsy}, 8'h00);
		rd(1'b0, 8'h04);
		txq.delete();
		// Chip reset command, then master reset, mid conclude
		lag = 30;
		txq.push_back(8'h02);
		issue(TSIL_CMD_CONCLUDE);
		cycles(10);
		issue(TSIL_CMD_CHIP_RESET);
		cycles(3);
		@(negedge mclk);
		check("busy after chip reset", {7'h0, cmd_busy}, 8'h00);
		txq.push_back(8'h02);
		issue(TSIL_CMD_CONCLUDE);
		cycles(10);
		rst <= 1'b1;
		cycles(2);
		rst <= 1'b0;
		@(negedge mclk);
		check("busy after reset", {7'h0, cmd_busy}, 8'h00);
		lag = 0;
		txq.delete();
		cycles(60);
		// Event arriving during a read is held for after it
		rd_begin(1'b0);
		bus_rst_in <= 1'b1;
		@(posedge mclk);
		bus_rst_in <= 1'b0;
		cycles(4);
		@(negedge mclk);
		check("snapshot", stat_rd_data, 8'h00);
		check("poll bit", {7'h0, int_pending}, 8'h00);
		rd_end();
		check("request line", {7'h0, irq_request_line}, 8'h01);
		rd(1'b0, 8'h04);
		conclude();
	end

	// Watchdog well beyond the expected run length
	initial begin
		#750000;
		num_errors++;
		conclude();
	end
endmodule
